// ### inc/part_consts.vh
/*
  Register offsets, field positions and reset values of the PWM
  auto-reload timer. Assumes a 32-bit AXI4-Lite register slave.
*/
`ifndef PART_CONSTS_VH
`define PART_CONSTS_VH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------
`define PART_IDX_DUTY3    8'h73
`define PART_IDX_DUTY2    8'h74
`define PART_IDX_DUTY1    8'h75
`define PART_IDX_DUTY0    8'h76
`define PART_IDX_WOCR     8'h77
`define PART_IDX_TCSR     8'h78
`define PART_IDX_CNT      8'h79
`define PART_IDX_RELOAD   8'h7A
`define PART_IDX_CCSR     8'h7B
`define PART_IDX_CAP1     8'h7C
`define PART_IDX_CAP2     8'h7D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PART_TCSR_EXT     7
`define PART_TCSR_DIV_HI  6
`define PART_TCSR_DIV_LO  4
`define PART_TCSR_RUN     3
`define PART_TCSR_FRL     2
`define PART_TCSR_IEN     1
`define PART_TCSR_WRAP    0

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define PART_RST8         8'h00
`define PART_RESP_OKAY    2'h0
`define PART_RESP_SLVERR  2'h2

`endif

// ### hdl/part_timer.v
/*
  8-bit auto-reload PWM timer with 7-bit prescaler, four PWM
  channels and two input-capture channels, behind an AXI4-Lite
  slave. Assumes pins (event clock, capture inputs) are
  asynchronous to aclk; event clock well below aclk / 4.
*/
// Notes on behaviour
// - Run bit clear freezes prescaler and counter; set lets counter advance.
// - Force-reload bit reads zero; writing one loads reload, clears prescaler.
// - Overflow request is wrap flag gated by wrap interrupt enable.
// - Wrap flag sets on FFh to reload passage; control read clears it.
// - Counter register reads live count; write replaces count, counting on.
// - Overflow loads reload value and sets outputs to polarity level.
// - Reload sets PWM period and resolution; zero gives full 8 bits.
// - Upper nibble of PWM control enables each channel onto its pin.
// - Polarity zero: high while count at or below compare, else low.
// - Polarity change inverts that output immediately; here the output flop applies it one aclk after the write lands.
// - Duty register sets second edge; reload sets common first edge.
// - Top two bits of capture control read as zero.
// - Edge select zero captures on falling edge, one on rising.
// - Each capture channel interrupt enable masks its request.
// - Capture sets flag; reading that capture register clears it.
// - Capture register holds counter value latched at capture.
// - All registers read zero after reset.
// - Hidden compare loads from duty register at each overflow.
// - Three-bit divide field picks one of eight prescaler taps.
// - External clock select picks event clock pin as prescaler input.
// - Capture register not overwritten until software has read it.
`timescale 1ns/1ps
`default_nettype none
`include "part_consts.vh"

module part_timer #(
  parameter NCH = 4
) (
  input  wire            aclk,
  input  wire            aresetn,
  input  wire [31:0]     s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [31:0]     s_axi_araddr,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  input  wire            event_clk,
  input  wire [1:0]      capture_pin,
  output reg  [NCH-1:0]  waveform_out,
  output wire [NCH-1:0]  waveform_oe,
  output wire            wrap_irq,
  output wire [1:0]      capture_irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0] meta_q;
  reg [2:0] sync_q;
  reg [2:0] prev_q;
  // Bit 2 is the event clock, bits 1:0 the capture pins.
  // A third stage keeps the previous level for edge detection,
  // so every edge costs three aclk cycles of latency.
  // Pulses shorter than about one aclk period may be lost.

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      prev_q <= 3'h0;
    end else begin
      meta_q <= {event_clk, capture_pin};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] duty_q [0:NCH-1];
  reg [7:0] shadow_compare_q [0:NCH-1];
  reg [7:0] wocr_q;
  reg [7:0] tcsr_q;
  reg [7:0] cnt_q;
  reg [7:0] reload_q;
  reg [5:0] ccsr_q;
  reg [7:0] cap_q [0:1];
  reg [6:0] presc_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  reg         aw_held_q;
  reg [7:0]   aw_idx_q;
  reg         aw_bad_q;
  reg         w_held_q;
  reg [7:0]   w_data_q;
  reg         w_lane_q;
  // Address and data are parked independently, so the master may
  // offer them in either order. The write lands one cycle after
  // both are parked, when the response is raised; a new address
  // or data beat is refused until that response has been taken.
  // Only byte lane 0 carries register data; a mapped write without it
  // is answered OKAY and changes nothing.

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

  wire wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_ok = wr_go && !aw_bad_q && w_lane_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q    <= 1'b0;
      aw_idx_q     <= 8'h00;
      aw_bad_q     <= 1'b0;
      w_held_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_lane_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
        aw_bad_q  <= (s_axi_awaddr[31:10] != 22'h0) ||
                     (s_axi_awaddr[9:2] < `PART_IDX_DUTY3) ||
                     (s_axi_awaddr[9:2] > `PART_IDX_CCSR);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_bad_q ? `PART_RESP_SLVERR : `PART_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  // Read data are taken from the live registers at the edge that
  // accepts the address, so side-effect clears land at that edge.
  wire       rd_go  = s_axi_arvalid && s_axi_arready;
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire       rd_hi  = s_axi_araddr[31:10] != 22'h0;

  reg [7:0] rd_val;
  reg       rd_bad;
  always @* begin
    rd_val = 8'h00;
    rd_bad = rd_hi;
    case (rd_idx)
      `PART_IDX_DUTY3:  rd_val = duty_q[3];
      `PART_IDX_DUTY2:  rd_val = duty_q[2];
      `PART_IDX_DUTY1:  rd_val = duty_q[1];
      `PART_IDX_DUTY0:  rd_val = duty_q[0];
      `PART_IDX_WOCR:   rd_val = wocr_q;
      `PART_IDX_TCSR:   rd_val = tcsr_q & 8'hFB;
      `PART_IDX_CNT:    rd_val = cnt_q;
      `PART_IDX_RELOAD: rd_val = reload_q;
      `PART_IDX_CCSR:   rd_val = {2'b00, ccsr_q};
      `PART_IDX_CAP1:   rd_val = cap_q[0];
      `PART_IDX_CAP2:   rd_val = cap_q[1];
      default:          rd_bad = 1'b1;
    endcase
  end

  // Side-effect reads only count when the read is a mapped access
  wire rd_tcsr = rd_go && !rd_hi && rd_idx == `PART_IDX_TCSR;
  wire rd_cap1 = rd_go && !rd_hi && rd_idx == `PART_IDX_CAP1;
  wire rd_cap2 = rd_go && !rd_hi && rd_idx == `PART_IDX_CAP2;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_bad ? 8'h00 : rd_val};
      s_axi_rresp  <= rd_bad ? `PART_RESP_SLVERR : `PART_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  wire       ext_rise = sync_q[2] && !prev_q[2];
  wire       run      = tcsr_q[`PART_TCSR_RUN];
  // Prescaler input: every aclk or each event clock rising edge
  wire       in_tick  = tcsr_q[`PART_TCSR_EXT] ? ext_rise : 1'b1;
  wire [2:0] div_sel  = tcsr_q[`PART_TCSR_DIV_HI:`PART_TCSR_DIV_LO];
  wire [7:0] presc_n  = {1'b0, presc_q} + 8'h01;
  // Tap n ticks when the low n prescaler bits all roll over
  wire [7:0] tap_mask = (8'h01 << div_sel) - 8'h01;
  wire       cnt_tick = run && in_tick &&
                        ((presc_q & tap_mask[6:0]) == tap_mask[6:0]);
  wire       wrap     = cnt_tick && (cnt_q == 8'hFF);
  // A counter write or forced reload restarts the prescaler, so
  // counting resumes from a known phase; force reload wins when
  // both arrive together, which the bus cannot produce anyway.

  wire wr_tcsr = wr_ok && aw_idx_q == `PART_IDX_TCSR;
  wire frl     = wr_tcsr && w_data_q[`PART_TCSR_FRL];
  wire wr_cnt  = wr_ok && aw_idx_q == `PART_IDX_CNT;

  always @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= 7'h00;
      cnt_q   <= `PART_RST8;
    end else if (frl) begin
      presc_q <= 7'h00;
      cnt_q   <= reload_q;
    end else if (wr_cnt) begin
      presc_q <= 7'h00;
      cnt_q   <= w_data_q;
    end else if (run && in_tick) begin
      presc_q <= presc_n[6:0];
      if (cnt_tick)
        cnt_q <= wrap ? reload_q : cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Control registers; set of a flag wins over a clearing read
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      tcsr_q   <= `PART_RST8;
      wocr_q   <= `PART_RST8;
      reload_q <= `PART_RST8;
    end else begin
      if (wr_ok && aw_idx_q == `PART_IDX_WOCR)
        wocr_q <= w_data_q;
      if (wr_ok && aw_idx_q == `PART_IDX_RELOAD)
        reload_q <= w_data_q;
      if (wr_tcsr)
        tcsr_q[7:1] <= {w_data_q[7:3], 1'b0, w_data_q[1]};
      if (wrap)
        tcsr_q[`PART_TCSR_WRAP] <= 1'b1;
      else if (rd_tcsr)
        tcsr_q[`PART_TCSR_WRAP] <= 1'b0;
    end
  end

  assign wrap_irq = tcsr_q[`PART_TCSR_IEN] && tcsr_q[`PART_TCSR_WRAP];

  // ----------------------------------------------------------------
  // PWM channels
  // ----------------------------------------------------------------
  // Raw level is 1 at/below compare; polarity XORs combinationally
  // in the output flop so a polarity write acts next cycle.
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_pwm
      always @(posedge aclk) begin
        if (!aresetn) begin
          duty_q[gi]           <= `PART_RST8;
          shadow_compare_q[gi] <= `PART_RST8;
          waveform_out[gi]     <= 1'b0;
        end else begin
          if (wr_ok && aw_idx_q == (`PART_IDX_DUTY0 - gi))
            duty_q[gi] <= w_data_q;
          if (wrap)
            shadow_compare_q[gi] <= duty_q[gi];
          waveform_out[gi] <=
            (cnt_q <= shadow_compare_q[gi]) ^ wocr_q[gi];
        end
      end
      assign waveform_oe[gi] = wocr_q[4 + gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cap
      wire rise = sync_q[gi] && !prev_q[gi];
      wire fall = !sync_q[gi] && prev_q[gi];
      wire edge_hit = ccsr_q[4 + gi] ? rise : fall;
      wire rd_clr = (gi == 0) ? rd_cap1 : rd_cap2;
      // An edge arriving while the flag is set is dropped, so the
      // first captured value survives until software reads it.
      always @(posedge aclk) begin
        if (!aresetn) begin
          cap_q[gi]     <= `PART_RST8;
          ccsr_q[gi]    <= 1'b0;
        end else if (edge_hit && !ccsr_q[gi]) begin
          cap_q[gi]  <= cnt_q;
          ccsr_q[gi] <= 1'b1;
        end else if (rd_clr) begin
          ccsr_q[gi] <= 1'b0;
        end
      end
      assign capture_irq[gi] = ccsr_q[2 + gi] && ccsr_q[gi];
    end
  endgenerate

  // Software-owned capture control bits; flags live in g_cap.
  always @(posedge aclk) begin
    if (!aresetn)
      ccsr_q[5:2] <= 4'h0;
    else if (wr_ok && aw_idx_q == `PART_IDX_CCSR)
      ccsr_q[5:2] <= w_data_q[5:2];
  end

endmodule // part_timer

`default_nettype wire

// ### dv/part_timer_props.sv
/* Port checker for part_timer: bus answers, masking, read-only bits.
   Assumes the master offers write address and data together. */
`timescale 1ns/1ps
`default_nettype none
module part_timer_props #(
  parameter NCH = 4
) (
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic [31:0]    s_axi_awaddr,
  input wire logic           s_axi_awvalid,
  input wire logic           s_axi_awready,
  input wire logic [31:0]    s_axi_wdata,
  input wire logic           s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic           s_axi_bvalid,
  input wire logic [31:0]    s_axi_araddr,
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic [31:0]    s_axi_rdata,
  input wire logic [1:0]     s_axi_rresp,
  input wire logic           s_axi_rvalid,
  input wire logic [NCH-1:0] waveform_oe,
  input wire logic           wrap_irq,
  input wire logic [1:0]     capture_irq
);
  wire           wr_both = s_axi_awvalid && s_axi_awready
                           && s_axi_wvalid && s_axi_wready;
  wire           rd_take = s_axi_arvalid && s_axi_arready;
  wire [NCH-1:0] wd_oe   = s_axi_wdata[NCH+3:4];
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_quiet: assert property ($rose(aresetn) |->
    waveform_oe == '0 && !wrap_irq && capture_irq == 2'h0)
    else $error("outputs not idle after reset");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_unmapped_err: assert property (rd_take && s_axi_araddr == 32'h1C8
    |=> s_axi_rresp == 2'h2) else $error("unmapped read accepted");
  chk_reload_reads_zero: assert property (
    rd_take && s_axi_araddr == 32'h1E0 |=> !s_axi_rdata[2])
    else $error("force reload bit read as one");
  chk_wrap_irq_mask: assert property (
    rd_take && s_axi_araddr == 32'h1E0
    |=> (s_axi_rdata[1] & s_axi_rdata[0]) == $past(wrap_irq))
    else $error("wrap request not flag and enable");
  chk_cap_irq_mask: assert property (
    rd_take && s_axi_araddr == 32'h1EC
    |=> (s_axi_rdata[3:2] & s_axi_rdata[1:0]) == $past(capture_irq))
    else $error("capture request not flag and enable");
  chk_reserved_zero: assert property (
    rd_take && s_axi_araddr == 32'h1EC |=> s_axi_rdata[7:6] == 2'h0)
    else $error("reserved capture bits set");
  chk_oe_follow: assert property (
    wr_both && s_axi_awaddr == 32'h1DC |-> ##2 waveform_oe == $past(wd_oe, 2))
    else $error("output enables not as written");
endmodule // part_timer_props
bind part_timer part_timer_props #(.NCH(NCH)) u_props (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .waveform_oe, .wrap_irq,
  .capture_irq);
`default_nettype wire

// ### dv/part_pins_model.sv
/* Pin-side model: capture inputs and external event clock.
   Assumes calls are made just after a rising aclk edge. */
`timescale 1ns/1ps
`default_nettype none
module part_pins_model (
  input  wire logic       aclk,
  output var  logic       event_clk,
  output var  logic [1:0] capture_pin
);
  initial event_clk = 1'b0;
  initial capture_pin = 2'h0;
  // Levels held 6 clocks: the device resamples pins, pulses under about one aclk may be lost
  task automatic set_pin(input int ch, input logic v);
    capture_pin[ch] <= v;
    repeat (6) @(posedge aclk);
  endtask
  // Event clock rests low between pulses
  task automatic events(input int n);
    repeat (n) begin
      event_clk <= 1'b1;
      repeat (6) @(posedge aclk);
      event_clk <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask
endmodule // part_pins_model
`default_nettype wire

// ### dv/part_timer_tb_top.sv
/* Register-level bench for part_timer over AXI4-Lite.
   Assumes the pin model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module part_timer_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, event_clk, wrap_irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, capture_pin, capture_irq;
  wire  [31:0] s_axi_rdata;
  wire  [3:0]  waveform_out, waveform_oe;
  int          fail_count = 0, total_checks = 0, cycles = 0;
  part_timer u_part_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .event_clk, .capture_pin, .waveform_out, .waveform_oe, .wrap_irq,
    .capture_irq);
  part_pins_model u_part_pins_model (.aclk, .event_clk, .capture_pin);
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bready and rready stay high, so each answer is taken when it appears
  task automatic wr(input logic [31:0] a, input logic [7:0] d,
                    input logic [1:0] r = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    check("bresp", {6'h0, s_axi_bresp}, {6'h0, r});
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e,
                    input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    check($sformatf("reg %h", a), s_axi_rdata[7:0], e);
    check("rresp", {6'h0, s_axi_rresp}, {6'h0, r});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++) rd(32'h1CC + 4 * i, 8'h00);
    rd(32'h1C8, 8'h00, 2'h2);
    wr(32'h1F0, 8'h5A, 2'h2);
    for (int i = 0; i < 4; i++) wr(32'h1CC + 4 * i, 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 4; i++) rd(32'h1CC + 4 * i, 8'(8'h11 * (i + 1)));
    wr(32'h1E8, 8'hF0);
    wr(32'h1E0, 8'h06);
    rd(32'h1E0, 8'h02);
    tick(20);
    rd(32'h1E4, 8'hF0);
    wr(32'h1E4, 8'hFD);
    wr(32'h1E0, 8'h0A);
    tick(6);
    check("wrap_irq", {7'h0, wrap_irq}, 8'h01);
    wr(32'h1E0, 8'h02);
    rd(32'h1E0, 8'h03);
    rd(32'h1E0, 8'h02);
    check("wrap_irq", {7'h0, wrap_irq}, 8'h00);
    wr(32'h1E4, 8'h80);
    wr(32'h1DC, 8'hF0);
    tick(2);
    check("pwm", {waveform_oe, waveform_out}, 8'hF0);
    wr(32'h1DC, 8'hF5);
    tick(2);
    check("pwm", {waveform_oe, waveform_out}, 8'hF5);
    wr(32'h1E4, 8'h22);
    tick(2);
    check("pwm", {waveform_oe, waveform_out}, 8'hF2);
    wr(32'h1E4, 8'h55);
    wr(32'h1EC, 8'h1C);
    u_part_pins_model.set_pin(0, 1'b1);
    check("capture_irq", {6'h0, capture_irq}, 8'h01);
    wr(32'h1E4, 8'h66);
    u_part_pins_model.set_pin(0, 1'b0);
    u_part_pins_model.set_pin(0, 1'b1);
    rd(32'h1F0, 8'h55);
    check("capture_irq", {6'h0, capture_irq}, 8'h00);
    u_part_pins_model.set_pin(1, 1'b1);
    u_part_pins_model.set_pin(1, 1'b0);
    check("capture_irq", {6'h0, capture_irq}, 8'h02);
    rd(32'h1EC, 8'h1E);
    rd(32'h1F4, 8'h66);
    wr(32'h1E4, 8'hFE);
    wr(32'h1E0, 8'h08);
    tick(4);
    check("wrap_irq", {7'h0, wrap_irq}, 8'h00);
    rd(32'h1E0, 8'h09);
    wr(32'h1E0, 8'h00);
    wr(32'h1E4, 8'h00);
    wr(32'h1E0, 8'h28);
    tick(13);
    wr(32'h1E0, 8'h20);
    tick(10);
    rd(32'h1E4, 8'h04);
    wr(32'h1EC, 8'h10);
    u_part_pins_model.set_pin(0, 1'b0);
    u_part_pins_model.set_pin(0, 1'b1);
    check("capture_irq", {6'h0, capture_irq}, 8'h00);
    rd(32'h1EC, 8'h11);
    wr(32'h1E0, 8'h80);
    wr(32'h1E4, 8'h10);
    wr(32'h1E0, 8'h88);
    u_part_pins_model.events(3);
    rd(32'h1E4, 8'h13);
    wrap_up();
  end
endmodule // part_timer_tb_top
`default_nettype wire
